// [design/ipce_map.svh]
// Register offsets, field positions and reset values of the interrupt pin block
`ifndef IPCE_MAP_SVH
`define IPCE_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define IPCE_OFS_PIN_CONFIG      8'h28
`define IPCE_OFS_SOURCE_ENABLE   8'h29
`define IPCE_OFS_PIN_ROUTING     8'h2A

// ****************************************************************
// Pin configuration fields
// ****************************************************************
`define IPCE_BIT_PIN_A_POLARITY  5
`define IPCE_BIT_PIN_A_DRIVE     4
`define IPCE_BIT_PIN_B_POLARITY  1
`define IPCE_BIT_PIN_B_DRIVE     0
`define IPCE_PIN_CONFIG_WMASK    8'h33

// ****************************************************************
// Source bit positions, shared by enable and routing
// ****************************************************************
`define IPCE_BIT_DATA_READY      7
`define IPCE_BIT_FIFO            6
`define IPCE_BIT_PRESS_WINDOW    5
`define IPCE_BIT_TEMP_WINDOW     4
`define IPCE_BIT_PRESS_THRESHOLD 3
`define IPCE_BIT_TEMP_THRESHOLD  2
`define IPCE_BIT_PRESS_CHANGE    1
`define IPCE_BIT_TEMP_CHANGE     0

// ****************************************************************
// Reset values
// ****************************************************************
`define IPCE_RST_PIN_CONFIG      8'h00
`define IPCE_RST_SOURCE_ENABLE   8'h00
`define IPCE_RST_PIN_ROUTING     8'h00

`endif

// [design/ipce_pkg.sv]
// Types shared by the interrupt pin block
`default_nettype none

package ipce_pkg;

    // Event flags of the eight sources, msb first
    typedef struct packed {
        logic data_ready;
        logic fifo;
        logic press_window;
        logic temp_window;
        logic press_threshold;
        logic temp_threshold;
        logic press_change;
        logic temp_change;
    } ipce_src_type;

    // Electrical setup of one interrupt pin
    typedef struct packed {
        logic polarity;
        logic drive_mode;
    } ipce_pin_cfg_type;

    // Drive value and output enable of one pin
    typedef struct packed {
        logic out;
        logic oe;
    } ipce_pin_drv_type;

endpackage : ipce_pkg

`default_nettype wire

// [design/ipce_pin_driver.sv]
// Output stage of one interrupt pin: polarity and drive mode
`timescale 1ns/100ps
`default_nettype none

module ipce_pin_driver (
    // Clock and reset
    input  wire logic                      i_clock,
    input  wire logic                      i_arst_n,
    // Request and setup
    input  wire logic                      i_assert,
    input  wire ipce_pkg::ipce_pin_cfg_type i_cfg,
    // Pin
    output var  logic                      o_pin_out,
    output var  logic                      o_pin_oe
);

    ipce_pkg::ipce_pin_drv_type drv_d;
    ipce_pkg::ipce_pin_drv_type drv_q;

    always_comb begin
        if (i_cfg.drive_mode) begin
            drv_d.oe  = i_assert;
            drv_d.out = i_cfg.polarity;
        end else begin
            drv_d.oe  = 1'b1;
            drv_d.out = i_assert ? i_cfg.polarity : ~i_cfg.polarity;
        end
    end

    // Reset shows push-pull, active low, inactive: driven high
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            drv_q <= 2'h3;
        end else begin
            drv_q <= drv_d;
        end
    end

    assign o_pin_out = drv_q.out;
    assign o_pin_oe  = drv_q.oe;

endmodule : ipce_pin_driver

`default_nettype wire

// [design/ipce_top.sv]
// Interrupt enable, routing and pin configuration of the sensor
// Behaviour
// - Pin A polarity at bit 5: clear active low, set active high.
// - Pin A drive at bit 4: clear push-pull, set open drain.
// - Pin B polarity at bit 1: clear active low, set active high.
// - Pin B drive at bit 0: clear push-pull, set open drain.
// - Config bits 7:6 and 3:2 read zero, writes ignored.
// - A disabled source never touches either pin.
// - Each enabled source reaches exactly one pin, by its routing bit.
// - Enable bit 7 data ready, bit 6 FIFO; reset disabled.
// - Enable bit 5 pressure window, bit 4 temperature window; reset disabled.
// - Enable bit 3 pressure threshold, bit 2 temperature threshold; reset disabled.
// - Enable bit 1 pressure change, bit 0 temperature change; reset disabled.
// - Routing bit zero sends to pin B, one to pin A.
// - Each pin is the OR of enabled sources routed to it.
`timescale 1ns/100ps
`default_nettype none
`include "ipce_map.svh"

module ipce_top (
    // Clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_arst_n,
    // Register port
    input  wire logic                  i_reg_wr_en,
    input  wire logic                  i_reg_rd_en,
    input  wire logic [7:0]            i_reg_addr,
    input  wire logic [7:0]            i_reg_wr_data,
    output var  logic [7:0]            o_reg_rd_data,
    output var  logic                  o_reg_rd_valid,
    // Source event flags
    input  wire ipce_pkg::ipce_src_type i_src_flags,
    // Interrupt pins
    output var  logic                  o_irq_pin_a_out,
    output var  logic                  o_irq_pin_a_oe,
    output var  logic                  o_irq_pin_b_out,
    output var  logic                  o_irq_pin_b_oe
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0] pin_config_q;
    logic [7:0] pin_config_d;
    logic [7:0] source_enable_q;
    logic [7:0] source_enable_d;
    logic [7:0] pin_routing_q;
    logic [7:0] pin_routing_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic       rd_valid_q;
    logic       rd_valid_d;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    always_comb begin
        pin_config_d    = pin_config_q;
        source_enable_d = source_enable_q;
        pin_routing_d   = pin_routing_q;
        if (i_reg_wr_en) begin
            if (hit(i_reg_addr, `IPCE_OFS_PIN_CONFIG)) begin
                pin_config_d = i_reg_wr_data & `IPCE_PIN_CONFIG_WMASK;
            end
            if (hit(i_reg_addr, `IPCE_OFS_SOURCE_ENABLE)) begin
                source_enable_d = i_reg_wr_data;
            end
            if (hit(i_reg_addr, `IPCE_OFS_PIN_ROUTING)) begin
                pin_routing_d = i_reg_wr_data;
            end
        end
        rd_valid_d = i_reg_rd_en;
        rd_data_d  = rd_data_q;
        if (i_reg_rd_en) begin
            // Unmapped offsets answer zero
            if (hit(i_reg_addr, `IPCE_OFS_PIN_CONFIG)) begin
                rd_data_d = pin_config_q;
            end else if (hit(i_reg_addr, `IPCE_OFS_SOURCE_ENABLE)) begin
                rd_data_d = source_enable_q;
            end else if (hit(i_reg_addr, `IPCE_OFS_PIN_ROUTING)) begin
                rd_data_d = pin_routing_q;
            end else begin
                rd_data_d = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_config_q    <= `IPCE_RST_PIN_CONFIG;
            source_enable_q <= `IPCE_RST_SOURCE_ENABLE;
            pin_routing_q   <= `IPCE_RST_PIN_ROUTING;
            rd_data_q       <= 8'h00;
            rd_valid_q      <= 1'b0;
        end else begin
            pin_config_q    <= pin_config_d;
            source_enable_q <= source_enable_d;
            pin_routing_q   <= pin_routing_d;
            rd_data_q       <= rd_data_d;
            rd_valid_q      <= rd_valid_d;
        end
    end

    assign o_reg_rd_data  = rd_data_q;
    assign o_reg_rd_valid = rd_valid_q;

    // ****************************************************************
    // Gating and routing
    // ****************************************************************
    logic [7:0]                 gated_src;
    logic                       req_pin_a;
    logic                       req_pin_b;
    ipce_pkg::ipce_pin_cfg_type cfg_pin_a;
    ipce_pkg::ipce_pin_cfg_type cfg_pin_b;

    always_comb begin
        // One enable per source
        // Bit order of the struct matches the enable register positions
        gated_src = i_src_flags & source_enable_q;
        req_pin_a = |(gated_src & pin_routing_q);
        req_pin_b = |(gated_src & ~pin_routing_q);
        cfg_pin_a.polarity   = pin_config_q[`IPCE_BIT_PIN_A_POLARITY];
        cfg_pin_a.drive_mode = pin_config_q[`IPCE_BIT_PIN_A_DRIVE];
        cfg_pin_b.polarity   = pin_config_q[`IPCE_BIT_PIN_B_POLARITY];
        cfg_pin_b.drive_mode = pin_config_q[`IPCE_BIT_PIN_B_DRIVE];
    end

    // ****************************************************************
    // Pin stages
    // ****************************************************************
    // Registered stage keeps pins glitch free at one cycle of latency
    ipce_pin_driver u_pin_a (
        .i_clock   (i_clock),
        .i_arst_n  (i_arst_n),
        .i_assert  (req_pin_a),
        .i_cfg     (cfg_pin_a),
        .o_pin_out (o_irq_pin_a_out),
        .o_pin_oe  (o_irq_pin_a_oe)
    );

    ipce_pin_driver u_pin_b (
        .i_clock   (i_clock),
        .i_arst_n  (i_arst_n),
        .i_assert  (req_pin_b),
        .i_cfg     (cfg_pin_b),
        .o_pin_out (o_irq_pin_b_out),
        .o_pin_oe  (o_irq_pin_b_oe)
    );

    // ****************************************************************
    // Assertions
    // ****************************************************************
    function automatic logic active(input logic out, input logic oe, input logic pol);
        active = oe && (out == pol);
    endfunction : active

    sequence s_cfg_write(logic [7:0] ofs);
        i_reg_wr_en && (i_reg_addr == ofs);
    endsequence

    property p_reserved_zero;
        @(posedge i_clock) disable iff (!i_arst_n)
        (pin_config_q & ~`IPCE_PIN_CONFIG_WMASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_enable_write;
        @(posedge i_clock) disable iff (!i_arst_n)
        s_cfg_write(`IPCE_OFS_SOURCE_ENABLE) |=> source_enable_q == $past(i_reg_wr_data);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not stored");

    property p_readback;
        @(posedge i_clock) disable iff (!i_arst_n)
        i_reg_rd_en && !i_reg_wr_en && (i_reg_addr == `IPCE_OFS_PIN_CONFIG)
        |=> o_reg_rd_valid && o_reg_rd_data == pin_config_q;
    endproperty
    a_readback: assert property (p_readback) else $error("config readback wrong");

    property p_disabled_silent;
        @(posedge i_clock) disable iff (!i_arst_n)
        (source_enable_q == 8'h00) ##1 (source_enable_q == 8'h00 && $stable(pin_config_q))
        |-> !active(o_irq_pin_a_out, o_irq_pin_a_oe, cfg_pin_a.polarity)
            && !active(o_irq_pin_b_out, o_irq_pin_b_oe, cfg_pin_b.polarity);
    endproperty
    a_disabled_silent: assert property (p_disabled_silent) else $error("disabled source fired");

    property p_pin_a_or;
        @(posedge i_clock) disable iff (!i_arst_n)
        ##1 $stable(pin_config_q) |->
        active(o_irq_pin_a_out, o_irq_pin_a_oe, cfg_pin_a.polarity)
            == |($past(i_src_flags) & $past(source_enable_q) & $past(pin_routing_q));
    endproperty
    a_pin_a_or: assert property (p_pin_a_or) else $error("pin A not OR of sources");

    property p_pin_b_route;
        @(posedge i_clock) disable iff (!i_arst_n)
        ##1 $stable(pin_config_q) |->
        active(o_irq_pin_b_out, o_irq_pin_b_oe, cfg_pin_b.polarity)
            == |($past(i_src_flags) & $past(source_enable_q) & ~$past(pin_routing_q));
    endproperty
    a_pin_b_route: assert property (p_pin_b_route) else $error("pin B routing wrong");

    property p_one_pin;
        @(posedge i_clock) disable iff (!i_arst_n)
        $onehot(i_src_flags & source_enable_q) ##1 $stable(pin_config_q)
        |-> active(o_irq_pin_a_out, o_irq_pin_a_oe, cfg_pin_a.polarity)
            != active(o_irq_pin_b_out, o_irq_pin_b_oe, cfg_pin_b.polarity);
    endproperty
    a_one_pin: assert property (p_one_pin) else $error("source on both or no pin");

    property p_push_pull;
        @(posedge i_clock) disable iff (!i_arst_n)
        !cfg_pin_a.drive_mode ##1 !cfg_pin_a.drive_mode |-> o_irq_pin_a_oe;
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("push-pull pin released");

    property p_od_idle;
        @(posedge i_clock) disable iff (!i_arst_n)
        cfg_pin_b.drive_mode && !req_pin_b |=> !o_irq_pin_b_oe;
    endproperty
    a_od_idle: assert property (p_od_idle) else $error("open-drain idle driven");

    property p_pol_b;
        @(posedge i_clock) disable iff (!i_arst_n)
        !cfg_pin_b.drive_mode && !req_pin_b |=> o_irq_pin_b_out == !$past(cfg_pin_b.polarity);
    endproperty
    a_pol_b: assert property (p_pol_b) else $error("pin B idle level wrong");

    property p_od_b_drive;
        @(posedge i_clock) disable iff (!i_arst_n)
        cfg_pin_b.drive_mode && req_pin_b |=> o_irq_pin_b_oe;
    endproperty
    a_od_b_drive: assert property (p_od_b_drive) else $error("open-drain B not driven");

    property p_pol_a;
        @(posedge i_clock) disable iff (!i_arst_n)
        req_pin_a |=> o_irq_pin_a_out == $past(cfg_pin_a.polarity);
    endproperty
    a_pol_a: assert property (p_pol_a) else $error("pin A active level wrong");

    property p_change_enables;
        @(posedge i_clock) disable iff (!i_arst_n)
        s_cfg_write(`IPCE_OFS_SOURCE_ENABLE) ##1 (i_src_flags.temp_change
            && !pin_routing_q[`IPCE_BIT_TEMP_CHANGE] && source_enable_q == 8'h01)
        |=> o_irq_pin_b_oe;
    endproperty
    a_change_enables: assert property (p_change_enables) else $error("change source lost");

    property p_threshold_enable;
        @(posedge i_clock) disable iff (!i_arst_n)
        i_src_flags.press_threshold && source_enable_q == 8'h08
            && pin_routing_q[`IPCE_BIT_PRESS_THRESHOLD] |=> o_irq_pin_a_oe;
    endproperty
    a_threshold_enable: assert property (p_threshold_enable) else $error("threshold lost");

endmodule : ipce_top

`default_nettype wire

// [verification/ipce_host_model.sv]
// Host side of the two interrupt lines: pull-ups and line resolution
`timescale 1ns/100ps
`default_nettype none

module ipce_host_model (
    // Device pin drivers
    input  wire logic i_pin_a_out,
    input  wire logic i_pin_a_oe,
    input  wire logic i_pin_b_out,
    input  wire logic i_pin_b_oe,
    // Resolved line levels seen by the host
    output var  logic o_line_a,
    output var  logic o_line_b
);
    // ****************************************************************
    // Line resolution
    // ****************************************************************
    // released line pulled up
    // Host keeps a pull-up, so a released line never floats to a guess
    always_comb begin
        o_line_a = i_pin_a_oe ? i_pin_a_out : 1'b1;
        o_line_b = i_pin_b_oe ? i_pin_b_out : 1'b1;
    end
endmodule : ipce_host_model
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench of the interrupt enable, routing and pin block
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module testbench;
    logic                   clk;
    logic                   arst_n;
    logic                   wr_en;
    logic                   rd_en;
    logic [7:0]             addr;
    logic [7:0]             wdata;
    logic [7:0]             rdata;
    logic                   rvalid;
    ipce_pkg::ipce_src_type flags;
    logic                   a_out;
    logic                   a_oe;
    logic                   b_out;
    logic                   b_oe;
    logic                   line_a;
    logic                   line_b;
    int                     n_errors = 0;
    int                     checked = 0;

    always #12.5 clk = ~clk;

    ipce_top ipce_top_i (
        .i_clock        (clk),
        .i_arst_n       (arst_n),
        .i_reg_wr_en    (wr_en),
        .i_reg_rd_en    (rd_en),
        .i_reg_addr     (addr),
        .i_reg_wr_data  (wdata),
        .o_reg_rd_data  (rdata),
        .o_reg_rd_valid (rvalid),
        .i_src_flags    (flags),
        .o_irq_pin_a_out(a_out),
        .o_irq_pin_a_oe (a_oe),
        .o_irq_pin_b_out(b_out),
        .o_irq_pin_b_oe (b_oe)
    );

    ipce_host_model ipce_host_model_i (
        .i_pin_a_out(a_out),
        .i_pin_a_oe (a_oe),
        .i_pin_b_out(b_out),
        .i_pin_b_oe (b_oe),
        .o_line_a   (line_a),
        .o_line_b   (line_b)
    );

    // ****************************************************************
    // Register access
    // ****************************************************************
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        `CHK(rvalid, 1'b1)
        `CHK(rdata, e)
    endtask : reg_rd

    // ****************************************************************
    // Pin checks
    // ****************************************************************
    task automatic chk_pin(input logic act, input logic pol, input logic drv,
                           input logic oe, input logic line);
        logic e_oe;
        e_oe = act | ~drv;
        `CHK(oe, e_oe)
        `CHK(line, e_oe ? (act ? pol : ~pol) : 1'b1)
    endtask : chk_pin

    task automatic run_case(input logic [7:0] c, input logic [7:0] en,
                            input logic [7:0] rt, input logic [7:0] f);
        logic [7:0] cm;
        cm = c & 8'h33;
        reg_wr(8'h28, c);
        reg_wr(8'h29, en);
        reg_wr(8'h2A, rt);
        reg_rd(8'h28, cm);
        reg_rd(8'h29, en);
        reg_rd(8'h2A, rt);
        @(posedge clk);
        flags <= f;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_pin(|(f & en & rt), cm[5], cm[4], a_oe, line_a);
        chk_pin(|(f & en & ~rt), cm[1], cm[0], b_oe, line_b);
    endtask : run_case

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    initial begin
        #(25 * 20000);
        n_errors++;
        finish_test();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        logic [7:0] cfgs [5];
        cfgs = '{8'h00, 8'h33, 8'h11, 8'h22, 8'hFF};
        clk    = 1'b0;
        arst_n = 1'b0;
        wr_en  = 1'b0;
        rd_en  = 1'b0;
        addr   = 8'h00;
        wdata  = 8'h00;
        flags  = '0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        // Idle pins after reset: push-pull, active low
        `CHK(a_oe, 1'b1)
        `CHK(a_out, 1'b1)
        `CHK(b_oe, 1'b1)
        `CHK(b_out, 1'b1)
        reg_rd(8'h28, 8'h00);
        reg_rd(8'h29, 8'h00);
        reg_rd(8'h2A, 8'h00);
        reg_wr(8'h2B, 8'hFF);
        reg_rd(8'h2B, 8'h00);
        $display("test reset_and_map done");

        run_case(8'h00, 8'h00, 8'h00, 8'hFF);
        run_case(8'h00, 8'h01, 8'h00, 8'h01);
        $display("test basic done");

        // One source at a time, the rest flagging but disabled
        for (int i = 0; i < 8; i++) begin
            run_case(8'h00, 8'h01 << i, 8'hAA, 8'hFF);
            run_case(8'h00, 8'h01 << i, 8'h55, 8'hFF);
            run_case(8'h00, 8'h01 << i, 8'hAA, ~(8'h01 << i));
        end
        $display("test per_source done");

        // Every polarity and drive mode, asserted and idle
        foreach (cfgs[k]) begin
            run_case(cfgs[k], 8'hFF, 8'h0F, 8'h30);
            run_case(cfgs[k], 8'hFF, 8'h0F, 8'h03);
            run_case(cfgs[k], 8'h81, 8'h80, 8'h81);
            run_case(cfgs[k], 8'hFF, 8'h0F, 8'h00);
        end
        $display("test pin_modes done");

        // Reset in mid-run returns registers and pins to idle
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        `CHK(a_oe, 1'b1)
        `CHK(a_out, 1'b1)
        `CHK(b_oe, 1'b1)
        `CHK(b_out, 1'b1)
        reg_rd(8'h28, 8'h00);
        reg_rd(8'h29, 8'h00);
        reg_rd(8'h2A, 8'h00);
        $display("test mid_reset done");
        finish_test();
    end
endmodule : testbench
`default_nettype wire
